// >>> verilog/emb_pkg.sv
package emb_pkg;

    // ----------------------------------------------------------------
    // memory map
    // ----------------------------------------------------------------
    localparam logic [13:0] DM_INT_BASE = 14'h3800;
    localparam logic [13:0] DM_RSV_BASE_LARGE = 14'h3c00;
    localparam logic [13:0] DM_RSV_BASE_SMALL = 14'h3a00;
    localparam logic [13:0] DM_TOP = 14'h3fff;
    localparam int ZONE_SHIFT = 11;
    localparam logic [2:0] ZONE_LAST = 3'h4;
    localparam int NUM_ZONES = 5;
    localparam int WS_W = 3;

    // ----------------------------------------------------------------
    // boot space
    // ----------------------------------------------------------------
    localparam logic [12:0] PAGE_MASK_LARGE = 13'h1fff;
    localparam logic [12:0] PAGE_MASK_SMALL = 13'h0fff;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    localparam logic [23:0] BOOT_PAGE_OE = 24'hc00000;
    localparam logic [23:0] DM_DATA_OE = 24'hffff00;
    localparam int SYNC_DEPTH = 2;

    // ----------------------------------------------------------------
    // register offsets and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_SYSCTL = 8'h00;
    localparam logic [7:0] REG_DWAIT = 8'h04;
    localparam logic [7:0] REG_BOOTLEN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int SC_PAGE_LSB = 0;
    localparam int SC_FORCE_BIT = 3;
    localparam int SC_BWAIT_LSB = 4;
    localparam int SC_GO_BIT = 7;
    localparam int SC_W = 8;
    localparam logic [SC_W-1:0] SYSCTL_RST = 8'h30;
    localparam logic [14:0] DWAIT_RST = 15'h7fff;
    localparam logic [13:0] BOOTLEN_RST = 14'h0100;
    localparam logic [2:0] BWAIT_RST = 3'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DM = 3'b001,
        ST_BOOT = 3'b010,
        ST_GRANT = 3'b011
    } emb_state_e;

    typedef struct packed {
        logic [13:0] addr;
        logic addr_oe;
        logic [23:0] data_drive;
        logic [23:0] data_oe;
        logic data_space_select_n;
        logic program_space_select_n;
        logic boot_space_select_n;
        logic rd_n;
        logic wr_n;
        logic ctl_oe;
    } emb_pins_s;

    localparam emb_pins_s PINS_IDLE = '{14'h0000, 1'b1, 24'h000000, 24'h000000,
                                        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam emb_pins_s PINS_FLOAT = '{14'h0000, 1'b0, 24'h000000, 24'h000000,
                                         1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage

// >>> verilog/emb_sync.sv
module emb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// >>> verilog/emb_ext_mem.sv
// Summary of operation
// RULE_01 - data space select goes low for every external data access.
// RULE_02 - write strobe goes low during external writes.
// RULE_03 - read strobe goes low during external reads.
// RULE_04 - peripherals in data space use the same cycles as data memory.
// RULE_05 - large variant: internal RAM 0x3800 for 1K, 0x3C00-0x3FFF reserved.
// RULE_06 - small variant: internal RAM 512 words, 0x3A00-0x3FFF reserved.
// RULE_07 - remaining 14K external, five zones, each own wait count.
// RULE_08 - all zone wait counts reset to seven.
// RULE_09 - large variant boot space 64K bytes, eight 8K pages.
// RULE_10 - small variant boot space 32K bytes, eight 4K pages.
// RULE_11 - boot reads bytes, packs three into a 24-bit program word.
// RULE_12 - three page bits in system control pick the boot page.
// RULE_13 - software force bit in system control starts a new boot.
// RULE_14 - map select low at reset release boots page 0 automatically.
// RULE_15 - boot waits programmable zero to seven, default three.
// RULE_16 - boot uses boot select and read strobe, byte from D8-D15.
// RULE_17 - page number driven on D23, D22 and A13 during boot.
// RULE_18 - bus request during boot granted after current byte finishes.
// RULE_19 - external master holds bus request low while it needs buses.
// RULE_20 - idle bus request: next cycle float buses, grant, halt.
// RULE_21 - go mode keeps running internally, halts on external need.
// RULE_22 - 14-bit address bus, 24-bit data bus, upper 16 for data.
// RULE_23 - request released: drop grant, drive buses again, resume.
// RULE_24 - external access stretched by its zone wait count.
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
module emb_ext_mem #(
    parameter bit LARGE_MEM = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic [13:0] core_addr,
    input wire logic [15:0] core_wdata,
    input wire logic core_ext_need,
    output logic core_done,
    output logic [15:0] core_rdata,
    output logic core_halt,
    input wire logic [23:0] dm_data_bus,
    output emb_pkg::emb_pins_s pins,
    input wire logic bus_request_n,
    output logic bus_grant_n,
    input wire logic memory_map_select,
    output logic pm_we,
    output logic [13:0] pm_addr,
    output logic [23:0] pm_wdata,
    output logic boot_busy
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [25:0] sync_q;
    logic br_s;
    logic memory_map_select_s;
    logic [23:0] data_s;

    emb_sync #(.W(26), .RST_VAL(26'h3000000)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({bus_request_n, memory_map_select, dm_data_bus}),
        .sync_out(sync_q)
    );
    assign br_s = sync_q[25];
    assign memory_map_select_s = sync_q[24];
    assign data_s = sync_q[23:0];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    localparam logic [13:0] RSV_BASE = LARGE_MEM ? emb_pkg::DM_RSV_BASE_LARGE
                                                 : emb_pkg::DM_RSV_BASE_SMALL;
    localparam logic [12:0] PAGE_MASK = LARGE_MEM ? emb_pkg::PAGE_MASK_LARGE
                                                  : emb_pkg::PAGE_MASK_SMALL;

    // internal RAM and the reserved control block never reach the pins
    function automatic logic is_external(input logic [13:0] a);
        is_external = (a < emb_pkg::DM_INT_BASE); // [RULE_05] [RULE_06]
    endfunction

    // top zone is the 6K remainder below internal RAM
    function automatic logic [2:0] zone_wait(input logic [13:0] a, input logic [14:0] ws);
        logic [2:0] z;
        z = a[13:emb_pkg::ZONE_SHIFT];
        if (z > emb_pkg::ZONE_LAST) begin
            z = emb_pkg::ZONE_LAST;
        end
        zone_wait = ws[z*emb_pkg::WS_W +: emb_pkg::WS_W]; // [RULE_07]
    endfunction

    function automatic emb_pkg::emb_pins_s boot_pins(input logic [2:0] pg,
                                                     input logic [12:0] off);
        emb_pkg::emb_pins_s p;
        p = emb_pkg::PINS_IDLE;
        p.addr = {pg[0], off & PAGE_MASK}; // [RULE_09] [RULE_10] [RULE_17]
        p.data_drive = {pg[2:1], 22'h000000};
        p.data_oe = emb_pkg::BOOT_PAGE_OE;
        p.boot_space_select_n = 1'b0; // [RULE_16]
        p.rd_n = 1'b0;
        boot_pins = p;
    endfunction

    // ----------------------------------------------------------------
    // ahb-lite register slave
    // ----------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [emb_pkg::SC_W-1:0] sysctl_q;
    logic [14:0] dwait_q;
    logic [13:0] bootlen_q;
    logic force_boot;
    logic ahb_take;
    emb_pkg::emb_state_e state_q;

    assign ahb_take = hsel && hready && htrans[1];
    assign force_boot = wr_pend_q && (wr_addr_q == emb_pkg::REG_SYSCTL)
                        && hwdata[emb_pkg::SC_FORCE_BIT];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= ahb_take && hwrite;
            if (ahb_take) begin
                wr_addr_q <= haddr[7:0];
            end
            if (ahb_take && !hwrite) begin
                case (haddr[7:0])
                    emb_pkg::REG_SYSCTL: hrdata <= {24'h000000, sysctl_q};
                    emb_pkg::REG_DWAIT: hrdata <= {17'h00000, dwait_q};
                    emb_pkg::REG_BOOTLEN: hrdata <= {18'h00000, bootlen_q};
                    emb_pkg::REG_STATUS: hrdata <= {26'h0000000, boot_busy, core_halt,
                                                    ~bus_grant_n, state_q};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // force bit is a command and always reads back as zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sysctl_q <= emb_pkg::SYSCTL_RST; // [RULE_15]
            dwait_q <= emb_pkg::DWAIT_RST; // [RULE_08]
            bootlen_q <= emb_pkg::BOOTLEN_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                emb_pkg::REG_SYSCTL: begin
                    sysctl_q <= hwdata[emb_pkg::SC_W-1:0];
                    sysctl_q[emb_pkg::SC_FORCE_BIT] <= 1'b0;
                end
                emb_pkg::REG_DWAIT: dwait_q <= hwdata[14:0];
                emb_pkg::REG_BOOTLEN: bootlen_q <= hwdata[13:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // boot start sources
    // ----------------------------------------------------------------
    logic [1:0] rel_cnt_q;
    logic boot_auto;
    logic boot_pend_q;
    logic boot_start;

    // strap is read once the synchroniser has refilled after reset
    assign boot_auto = (rel_cnt_q == 2'(emb_pkg::SYNC_DEPTH)) && !memory_map_select_s;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rel_cnt_q <= 2'h0;
        end else if (rel_cnt_q != 2'h3) begin
            rel_cnt_q <= rel_cnt_q + 2'h1;
        end
    end

    // a new request in the starting cycle stays pending
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            boot_pend_q <= 1'b0;
        end else begin
            boot_pend_q <= boot_auto || force_boot || (boot_pend_q && !boot_start); // [RULE_13] [RULE_14]
        end
    end

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    logic [2:0] cnt_q;
    logic we_q;
    logic resume_q;
    logic [12:0] boff_q;
    logic [1:0] bidx_q;
    logic [13:0] wcnt_q;
    logic [23:0] word_q;
    logic [2:0] page_q;
    logic [2:0] bwait;
    logic [23:0] word_d;
    logic last_byte;
    logic [1:0] tail_q;

    assign bwait = sysctl_q[emb_pkg::SC_BWAIT_LSB +: 3];
    assign boot_start = (state_q == emb_pkg::ST_IDLE) && br_s && boot_pend_q;
    assign word_d = {word_q[15:0], data_s[15:8]}; // [RULE_11] [RULE_16]
    assign last_byte = (bidx_q == emb_pkg::LAST_BYTE) && (wcnt_q + 14'h1 >= bootlen_q);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= emb_pkg::ST_IDLE;
            pins <= emb_pkg::PINS_IDLE;
            bus_grant_n <= 1'b1;
            cnt_q <= 3'h0;
            we_q <= 1'b0;
            resume_q <= 1'b0;
            boff_q <= 13'h0000;
            bidx_q <= 2'h0;
            wcnt_q <= 14'h0000;
            word_q <= 24'h000000;
            page_q <= 3'h0;
            core_done <= 1'b0;
            core_rdata <= 16'h0000;
            pm_we <= 1'b0;
            pm_addr <= 14'h0000;
            pm_wdata <= 24'h000000;
            tail_q <= 2'h0;
        end else begin
            core_done <= 1'b0;
            pm_we <= 1'b0;
            // read data trails the strobe by the two pin-sync stages
            tail_q <= {tail_q[0], 1'b0};
            if (tail_q[1]) begin
                core_done <= 1'b1;
                core_rdata <= data_s[23:8]; // [RULE_22]
            end
            case (state_q)
                emb_pkg::ST_IDLE: begin
                    if (!br_s) begin
                        state_q <= emb_pkg::ST_GRANT; // [RULE_20]
                        pins <= emb_pkg::PINS_FLOAT;
                        bus_grant_n <= 1'b0;
                    end else if (boot_pend_q) begin
                        state_q <= emb_pkg::ST_BOOT;
                        page_q <= sysctl_q[emb_pkg::SC_PAGE_LSB +: 3]; // [RULE_12]
                        boff_q <= 13'h0000;
                        bidx_q <= 2'h0;
                        wcnt_q <= 14'h0000;
                        pm_addr <= 14'h0000;
                        cnt_q <= bwait;
                        pins <= boot_pins(sysctl_q[emb_pkg::SC_PAGE_LSB +: 3], 13'h0000);
                    end else if (core_req && !core_done && (tail_q == 2'h0)) begin
                        if (is_external(core_addr)) begin
                            // same cycle shape for memory and mapped peripherals
                            state_q <= emb_pkg::ST_DM; // [RULE_04]
                            we_q <= core_we;
                            cnt_q <= zone_wait(core_addr, dwait_q); // [RULE_24]
                            pins.addr <= core_addr; // [RULE_22]
                            pins.data_drive <= {core_wdata, 8'h00};
                            pins.data_oe <= core_we ? emb_pkg::DM_DATA_OE : 24'h000000;
                            pins.data_space_select_n <= 1'b0; // [RULE_01]
                            pins.rd_n <= core_we; // [RULE_03]
                            pins.wr_n <= !core_we; // [RULE_02]
                        end else begin
                            core_done <= 1'b1;
                        end
                    end
                end
                emb_pkg::ST_DM: begin
                    if (cnt_q == 3'h0) begin
                        tail_q <= 2'h1;
                        pins <= emb_pkg::PINS_IDLE;
                        state_q <= emb_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1; // [RULE_24]
                    end
                end
                emb_pkg::ST_BOOT: begin
                    if (cnt_q != 3'h0) begin
                        cnt_q <= cnt_q - 3'h1; // [RULE_15]
                    end else begin
                        word_q <= word_d;
                        boff_q <= boff_q + 13'h1;
                        if (bidx_q == emb_pkg::LAST_BYTE) begin
                            bidx_q <= 2'h0;
                            pm_we <= 1'b1; // [RULE_11]
                            pm_wdata <= word_d;
                            wcnt_q <= wcnt_q + 14'h1;
                        end else begin
                            bidx_q <= bidx_q + 2'h1;
                        end
                        if (last_byte) begin
                            resume_q <= 1'b0;
                            pins <= emb_pkg::PINS_IDLE;
                            state_q <= emb_pkg::ST_IDLE;
                        end else if (!br_s) begin
                            // byte is complete, only now hand over
                            resume_q <= 1'b1; // [RULE_18]
                            pins <= emb_pkg::PINS_FLOAT;
                            bus_grant_n <= 1'b0;
                            state_q <= emb_pkg::ST_GRANT;
                        end else begin
                            cnt_q <= bwait;
                            pins <= boot_pins(page_q, boff_q + 13'h1);
                        end
                    end
                    if (pm_we) begin
                        pm_addr <= pm_addr + 14'h1;
                    end
                end
                emb_pkg::ST_GRANT: begin
                    if (pm_we) begin
                        pm_addr <= pm_addr + 14'h1;
                    end
                    if (br_s) begin
                        bus_grant_n <= 1'b1; // [RULE_23]
                        if (resume_q) begin
                            resume_q <= 1'b0;
                            state_q <= emb_pkg::ST_BOOT;
                            cnt_q <= bwait;
                            pins <= boot_pins(page_q, boff_q);
                        end else begin
                            state_q <= emb_pkg::ST_IDLE;
                            pins <= emb_pkg::PINS_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= emb_pkg::ST_IDLE;
                    pins <= emb_pkg::PINS_IDLE;
                    bus_grant_n <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // execution halt
    // ----------------------------------------------------------------
    logic granted_next;
    logic booting_next;

    assign granted_next = (state_q == emb_pkg::ST_GRANT) ? !br_s
                        : ((state_q == emb_pkg::ST_IDLE) && !br_s);
    assign booting_next = boot_start || (state_q == emb_pkg::ST_BOOT)
                        || ((state_q == emb_pkg::ST_GRANT) && resume_q);

    // go mode halts during a grant only when the core asks for the outside world; a boot always halts
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_halt <= 1'b0;
            boot_busy <= 1'b0;
        end else begin
            boot_busy <= booting_next;
            core_halt <= booting_next || (granted_next
                         && (!sysctl_q[emb_pkg::SC_GO_BIT] || core_ext_need)); // [RULE_20] [RULE_21] [RULE_23]
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_dm_select: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (state_q == emb_pkg::ST_DM) |-> !pins.data_space_select_n && pins.boot_space_select_n)
        else $error("data select not low during external access");

    chk_wr_strobe: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
        (state_q == emb_pkg::ST_DM && we_q) |-> !pins.wr_n && pins.rd_n)
        else $error("write strobe wrong during external write");

    chk_rd_strobe: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (state_q == emb_pkg::ST_DM && !we_q) |-> !pins.rd_n && pins.wr_n)
        else $error("read strobe wrong during external read");

    chk_zone_reset: assert property (@(posedge clk) // [RULE_08]
        !rst_b |=> (dwait_q == emb_pkg::DWAIT_RST))
        else $error("zone waits not seven after reset");

    chk_boot_wait: assert property (@(posedge clk) // [RULE_15]
        !rst_b |=> (sysctl_q[emb_pkg::SC_BWAIT_LSB +: 3] == emb_pkg::BWAIT_RST))
        else $error("boot wait default not three");

    chk_grant_float: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_20]
        !bus_grant_n |-> !pins.ctl_oe && !pins.addr_oe && (pins.data_oe == 24'h000000))
        else $error("pins driven while bus granted");

    chk_grant_next: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_20]
        (state_q == emb_pkg::ST_IDLE && !br_s) |=> !bus_grant_n ##1 (core_halt || !br_s
        || sysctl_q[emb_pkg::SC_GO_BIT]))
        else $error("idle bus request not granted next cycle");

    chk_release: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_23]
        (state_q == emb_pkg::ST_GRANT && br_s) |=> bus_grant_n && pins.ctl_oe)
        else $error("grant not released");

    chk_boot_byte: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_18]
        (state_q == emb_pkg::ST_BOOT && cnt_q != 3'h0) |=> (state_q == emb_pkg::ST_BOOT))
        else $error("boot byte cut short");

    chk_dm_stretch: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_24]
        (state_q == emb_pkg::ST_DM && cnt_q != 3'h0) |=>
        (state_q == emb_pkg::ST_DM) && (cnt_q == $past(cnt_q) - 3'h1))
        else $error("external access not stretched");

endmodule

// >>> testbench/emb_mem_model.sv
module emb_mem_model (
    input wire logic clk,
    input wire emb_pkg::emb_pins_s pins,
    output logic [23:0] mem_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // external data memory and byte-wide boot memory
    // ----------------------------------------------------------------
    logic [15:0] mem [0:16383];
    logic [23:0] idle_q = 24'h5a5a5a;
    logic [23:0] val;
    logic [2:0] page;
    logic act;
    always_comb begin
        page = {pins.data_drive[23:22], pins.addr[13]};
        act = 1'b0;
        val = 24'h000000;
        if (!pins.data_space_select_n && !pins.rd_n) begin
            act = 1'b1;
            val = {mem[pins.addr], 8'h00};
        end else if (!pins.boot_space_select_n && !pins.rd_n) begin
            act = 1'b1;
            val = {8'h00, pins.addr[7:0] ^ {page, 5'h0b}, 8'h00};
        end
        mem_drive = act ? val : idle_q;
    end
    // released bus keeps changing so a stale value never passes
    always @(posedge clk) begin
        idle_q <= ~mem_drive;
        if (!pins.data_space_select_n && !pins.wr_n) begin
            mem[pins.addr] <= pins.data_drive[23:8];
        end
    end
endmodule

// >>> testbench/ext_mem_boot_bus_iface_tb.sv
module ext_mem_boot_bus_iface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, core_done, core_halt, bus_grant_n, pm_we, boot_busy;
    logic [31:0] hrdata, r, w32;
    logic core_req = 1'b0;
    logic core_we = 1'b0;
    logic [13:0] core_addr = 14'h0;
    logic [15:0] core_wdata = 16'h0;
    logic [15:0] core_rdata, d16, r16;
    logic [23:0] dm_data_bus, mem_drive, pm_wdata;
    logic [13:0] pm_addr, a;
    logic bus_request_n = 1'b1;
    logic core_ext_need = 1'b0;
    logic memory_map_select = 1'b1;
    logic [2:0] ws [5];
    logic [2:0] pg;
    emb_pkg::emb_pins_s pins;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 71939;
    int n, i;
    always #5 clk = ~clk;
    assign dm_data_bus = (pins.data_oe & pins.data_drive) | (~pins.data_oe & mem_drive);
    emb_ext_mem #(.LARGE_MEM(1'b1)) dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_req(core_req),
        .core_we(core_we), .core_addr(core_addr), .core_wdata(core_wdata),
        .core_ext_need(core_ext_need),
        .core_done(core_done), .core_rdata(core_rdata), .core_halt(core_halt),
        .dm_data_bus(dm_data_bus), .pins(pins), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .memory_map_select(memory_map_select), .pm_we(pm_we),
        .pm_addr(pm_addr), .pm_wdata(pm_wdata), .boot_busy(boot_busy));
    emb_mem_model mdl (.clk(clk), .pins(pins), .mem_drive(mem_drive));
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // counts cycles with select and the proper strobe both low
    task automatic core(input logic wr, input logic [13:0] ad, input logic [15:0] wd,
                        output logic [15:0] rd, output int cnt);
        int t;
        @(posedge clk);
        core_req <= 1'b1;
        core_we <= wr;
        core_addr <= ad;
        core_wdata <= wd;
        cnt = 0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (pins.data_space_select_n === 1'b0 && (wr ? pins.wr_n : pins.rd_n) === 1'b0) cnt++;
        end while (core_done !== 1'b1 && t < 100);
        rd = core_rdata;
        core_req <= 1'b0;
    endtask
    function automatic logic [7:0] bb(int k);
        return 8'(k) ^ {pg, 5'h0b};
    endfunction
    initial begin
        #100000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, r);
        check(r, 32'h30);
        ahb(1'b0, 32'h4, 32'h0, r);
        check(r, 32'h7fff);
        ahb(1'b0, 32'h10, 32'h0, r);
        check(r, 32'h0);
        w32 = 32'h0;
        for (i = 0; i < 5; i++) begin
            ws[i] = 3'({$random(seed)} % 7 + 1);
            w32[3*i +: 3] = ws[i];
        end
        ahb(1'b1, 32'h4, w32, r);
        for (i = 0; i < 5; i++) begin
            a = 14'(i * 'h800 + {$random(seed)} % (i == 4 ? 'h1800 : 'h800));
            d16 = 16'($random(seed));
            core(1'b1, a, d16, r16, n);
            check(n, ws[i] + 1);
            core(1'b0, a, 16'h0, r16, n);
            check(n, ws[i] + 1);
            check(r16, d16);
        end
        core(1'b0, 14'h3800 | 14'($random(seed) & 'h3ff), 16'h0, r16, n);
        check(n, 0);
        bus_request_n <= 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (bus_grant_n !== 1'b0 && n < 20);
        check({n < 6, pins.ctl_oe, pins.addr_oe, |pins.data_oe, core_halt}, 5'h11);
        ahb(1'b1, 32'h0, 32'h0b0, r);
        repeat (2) @(posedge clk);
        check(core_halt, 1'b0);
        core_ext_need <= 1'b1;
        repeat (2) @(posedge clk);
        check(core_halt, 1'b1);
        core_ext_need <= 1'b0;
        bus_request_n <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (bus_grant_n !== 1'b1 && n < 20);
        @(posedge clk);
        check({n < 6, pins.ctl_oe, pins.addr_oe}, 3'h7);
        pg = 3'($random(seed));
        ahb(1'b1, 32'h8, 32'h2, r);
        ahb(1'b1, 32'h0, {24'h0, 8'h38 | {5'h0, pg}}, r);
        for (i = 0; i < 6; i += 3) begin
            n = 0;
            do begin @(posedge clk); n++; end while (pm_we !== 1'b1 && n < 200);
            check({pm_addr[7:0], pm_wdata},
                  {8'(i / 3), bb(i), bb(i + 1), bb(i + 2)});
            if (i == 0) begin
                bus_request_n <= 1'b0;
                n = 0;
                do begin @(posedge clk); n++; end while (bus_grant_n !== 1'b0 && n < 20);
                check({bus_grant_n, pins.ctl_oe, boot_busy}, 3'h1);
                bus_request_n <= 1'b1;
            end
        end
        n = 0;
        do begin @(posedge clk); n++; end while (boot_busy !== 1'b0 && n < 200);
        check(boot_busy, 1'b0);
        rst_b <= 1'b0;
        memory_map_select <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (boot_busy !== 1'b1 && n < 20);
        check(boot_busy, 1'b1);
        print_verdict;
    end
endmodule
